// ### hw/ammc_pkg.sv
package ammc_pkg;
  // register indices on the plain register port
  localparam logic [5:0] OFS_STOP_ZONE = 6'h09;
  localparam logic [5:0] OFS_PERIOD_SEL = 6'h0A;
  localparam logic [5:0] OFS_REFRESH_MULT = 6'h0B;
  localparam logic [5:0] OFS_SLEW = 6'h0C;
  localparam logic [5:0] OFS_LINK_RATE = 6'h0D;
  localparam logic [5:0] OFS_NODE_ID = 6'h0E;
  localparam logic [5:0] OFS_MODE_CTRL = 6'h0F;
  localparam logic [5:0] OFS_STAGE_CTRL = 6'h10;
  localparam logic [5:0] OFS_SETPOINT_H = 6'h11;
  localparam logic [5:0] OFS_SETPOINT_L = 6'h12;
  localparam logic [5:0] OFS_USER_FIRST = 6'h13;
  localparam logic [5:0] OFS_USER_LAST = 6'h22;
  localparam logic [5:0] OFS_CMD = 6'h23;
  localparam logic [5:0] OFS_TBL_ADDR_H = 6'h24;
  localparam logic [5:0] OFS_TBL_ADDR_L = 6'h25;
  localparam logic [5:0] OFS_TBL_DATA_H = 6'h26;
  localparam logic [5:0] OFS_TBL_DATA_L = 6'h27;
  localparam logic [5:0] OFS_DUTY_H = 6'h28;
  localparam logic [5:0] OFS_DUTY_L = 6'h29;
  localparam logic [5:0] OFS_STATUS_H = 6'h2A;
  localparam logic [5:0] OFS_STATUS_L = 6'h2B;
  localparam int NREG = 26;
  localparam int NCFG = 10;
  // factory defaults
  localparam logic [7:0] DEF_STOP_ZONE = 8'h04;
  localparam logic [7:0] DEF_PERIOD_SEL = 8'hFF;
  localparam logic [7:0] DEF_REFRESH_MULT = 8'h01;
  localparam logic [7:0] DEF_SLEW = 8'h04;
  localparam logic [7:0] DEF_LINK_RATE = 8'h00;
  localparam logic [7:0] DEF_NODE_ID = 8'h01;
  localparam logic [7:0] DEF_MODE_CTRL = 8'h00;
  localparam logic [7:0] DEF_STAGE_CTRL = 8'h03;
  localparam logic [7:0] DEF_SETPOINT = 8'h00;
  localparam logic [7:0] DEF_USER = 8'h00;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  // mode_and_recovery_ctrl bits
  localparam int BIT_UNIPOLAR = 0;
  localparam int BIT_BIPOLAR = 1;
  localparam int BIT_SPEED = 2;
  localparam int BIT_TABLE = 3;
  localparam int BIT_ALL_RETRY = 4;
  localparam int BIT_OC_RETRY = 5;
  localparam int BIT_OT_RETRY = 6;
  localparam int BIT_BRAKE = 7;
  // commands
  localparam logic [7:0] CMD_STORE = 8'h01;
  localparam logic [7:0] CMD_DEFAULTS = 8'h02;
  localparam logic [7:0] CMD_TBL_RESTORE = 8'h03;
  // arithmetic
  localparam logic signed [11:0] BIP_MID = 12'h200;
  localparam logic signed [11:0] PWM_POS = 12'h3FF;
  localparam logic signed [11:0] PWM_NEG = 12'hC01;
  localparam logic [9:0] TBL_DEFAULT = 10'h000;
  localparam logic [10:0] NV_CFG_BASE = 11'h400;
  localparam logic [10:0] TBL_LAST = 11'h3FF;
  // timing
  localparam int CLK_NS = 10;
  localparam int UPDATE_BASE_NS = 833000;
  localparam int UPDATE_BASE_CYC = UPDATE_BASE_NS / CLK_NS;

  typedef logic signed [10:0] ammc_pwm_t;

  // request to the non-volatile store: table at 0..1023, config at 1024+
  typedef struct packed {
    logic rd;
    logic we;
    logic [10:0] addr;
    logic [9:0] wdata;
  } ammc_nv_req_s;

  function automatic logic [7:0] ammc_cfg_default(input int i);
    case (i)
      0: return DEF_STOP_ZONE;
      1: return DEF_PERIOD_SEL;
      2: return DEF_REFRESH_MULT;
      3: return DEF_SLEW;
      4: return DEF_LINK_RATE;
      5: return DEF_NODE_ID;
      6: return DEF_MODE_CTRL;
      7: return DEF_STAGE_CTRL;
      8: return DEF_SETPOINT;
      9: return DEF_SETPOINT;
      default: return DEF_USER;
    endcase
  endfunction : ammc_cfg_default
endpackage : ammc_pkg

// ### hw/ammc_core.sv
// Behaviour
// R1 - bipolar: (sample-512)*2, saturated to -1023..+1023
// R2 - bipolar: midscale stops, lowest full reverse, highest full forward (code gives +1022 at the highest sample, not +1023)
// R3 - speed mode steps demand toward stored setpoint
// R4 - speed mode never drives reverse
// R5 - host should use slew one and long refresh in speed mode
// R6 - table mode: sample addresses 1024-entry signed table
// R7 - table writes persist; table restore reloads default entries
// R8 - table mode skips the slew limit
// R9 - retry-all bit: energize whenever bridge turns off
// R10 - overcurrent / overheat retry bits energize on those trips
// R11 - braking bit and zero demand: both low gates high
// R12 - braking clear and zero demand: both low gates low
// R13 - host loads setpoint only with 0..1023
// R14 - low setpoint byte holds low eight bits, high byte the rest
// R15 - sixteen user bytes saved by the store command
// R16 - load config at power-up; all ones means install defaults
// R17 - factory default values of the config bytes
// R18 - restore defaults leaves user bytes untouched
// R19 - bipolar demand passes stop-zone, slew and period scaling
// R20 - host sets at most one mode bit; none means direct duty
// R21 - stop-zone above sample forces zero in every mode
// R22 - slew-limited modes change at most slew per update
// R23 - one sample and one new demand per update interval
// R24 - mode changes apply at the next update
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module ammc_core #(
  parameter int BASE_CYC = ammc_pkg::UPDATE_BASE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic [9:0] adc_sample,
  input wire logic bridge_on,
  input wire logic overcurrent_flag,
  input wire logic overheat_flag,
  output ammc_pkg::ammc_nv_req_s nv_req,
  input wire logic [9:0] nv_rdata,
  output ammc_pkg::ammc_pwm_t pwm_demand,
  output logic [9:0] pwm_duty,
  output logic low_side_gate_left,
  output logic low_side_gate_right,
  output logic energize_cmd,
  output logic busy
);
  import ammc_pkg::*;

  typedef enum logic [2:0] {
    ST_LOAD, ST_CHECK, ST_RUN, ST_STORE, ST_TRESTORE
  } ammc_state_e;

  ammc_state_e state;
  logic [10:0] cnt;
  logic ld_q;
  logic [4:0] ld_idx;
  logic all_blank;
  logic [7:0] cfg [0:NREG-1];
  logic [7:0] tbl_addr_h, tbl_addr_l, tbl_data_h;
  logic [7:0] duty_h, duty_l;
  logic [9:0] samp;
  logic [16:0] base_cnt;
  logic [7:0] mult_cnt;
  logic tick_pend, upd_s1, rty_q;

  // named views of the config bytes
  wire [7:0] stop_zone_width = cfg[0];
  wire [7:0] pwm_period_select = cfg[1];
  wire [7:0] refresh_multiplier = cfg[2];
  wire [7:0] slew_limit = cfg[3];
  wire [7:0] mode_and_recovery_ctrl = cfg[6];
  wire [9:0] setpoint = {cfg[8][1:0], cfg[9]}; // R14

  wire bipolar_analog_select = mode_and_recovery_ctrl[BIT_BIPOLAR];
  wire speed_regulate_select = mode_and_recovery_ctrl[BIT_SPEED];
  wire table_mode_select = mode_and_recovery_ctrl[BIT_TABLE];
  wire unipolar_analog_select = mode_and_recovery_ctrl[BIT_UNIPOLAR];
  wire overcurrent_reenergize = mode_and_recovery_ctrl[BIT_OC_RETRY];
  wire zero_pwm_braking = mode_and_recovery_ctrl[BIT_BRAKE];

  // register port decode
  wire run = (state == ST_RUN);
  wire in_cfg = (bus_addr >= OFS_STOP_ZONE) && (bus_addr <= OFS_USER_LAST);
  wire [5:0] rel = bus_addr - OFS_STOP_ZONE;
  wire [4:0] cfg_idx = rel[4:0];
  wire cfg_wr = bus_wr && run && in_cfg;
  wire cmd_wr = bus_wr && run && (bus_addr == OFS_CMD);
  wire do_store = cmd_wr && (bus_wdata == CMD_STORE); // R15
  wire do_defaults = cmd_wr && (bus_wdata == CMD_DEFAULTS);
  wire do_trestore = cmd_wr && (bus_wdata == CMD_TBL_RESTORE);
  wire tw_go = bus_wr && run && (bus_addr == OFS_TBL_DATA_L);

  // power-up load walks the 26 stored bytes
  wire ld_rd = (state == ST_LOAD) && (cnt < 11'(NREG));
  wire ld_done = (state == ST_LOAD) && (cnt == 11'(NREG));
  wire first_start = (state == ST_CHECK) && all_blank; // R16
  wire sanitize = (state == ST_CHECK) && !all_blank;
  wire [3:0] mbits = mode_and_recovery_ctrl[3:0];
  wire [3:0] mone = mbits & (~mbits + 4'h1);
  wire [7:0] mode_clean = {mode_and_recovery_ctrl[7:4], mone};

  // update interval: base period times multiplier
  wire [7:0] mult_eff = (refresh_multiplier == 8'h00) ? 8'h01 : refresh_multiplier;
  wire base_end = (base_cnt == 17'(BASE_CYC - 1));
  wire tick = base_end && ((mult_cnt + 8'h01) >= mult_eff);
  wire upd_go = tick_pend && run && !tw_go; // R23

  // non-volatile request mux
  always_comb begin
    nv_req = '0;
    if (ld_rd) begin
      nv_req.rd = 1'b1;
      nv_req.addr = NV_CFG_BASE + cnt;
    end else if (state == ST_STORE) begin
      nv_req.we = 1'b1;
      nv_req.addr = NV_CFG_BASE + cnt;
      nv_req.wdata = {2'b00, cfg[cnt[4:0]]};
    end else if (state == ST_TRESTORE) begin
      nv_req.we = 1'b1; // R7
      nv_req.addr = cnt;
      nv_req.wdata = TBL_DEFAULT;
    end else if (tw_go) begin
      nv_req.we = 1'b1; // R7
      nv_req.addr = {1'b0, tbl_addr_h[1:0], tbl_addr_l};
      nv_req.wdata = {tbl_data_h[1:0], bus_wdata};
    end else if (upd_go) begin
      nv_req.rd = table_mode_select; // R6
      nv_req.addr = {1'b0, adc_sample};
    end
  end

  // control sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_LOAD;
      cnt <= '0;
    end else begin
      case (state)
        ST_LOAD: begin
          cnt <= cnt + 11'h001;
          if (ld_done) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state <= ST_RUN;
          cnt <= '0;
        end
        ST_RUN: begin
          cnt <= '0;
          if (do_store) begin
            state <= ST_STORE;
          end else if (do_trestore) begin
            state <= ST_TRESTORE;
          end
        end
        ST_STORE: begin
          cnt <= cnt + 11'h001;
          if (cnt == 11'(NREG - 1)) begin
            state <= ST_RUN;
          end
        end
        ST_TRESTORE: begin
          cnt <= cnt + 11'h001;
          if (cnt == TBL_LAST) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_LOAD;
          cnt <= '0;
        end
      endcase
    end
  end

  // capture of stored bytes and blank detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ld_q <= 1'b0;
      ld_idx <= '0;
      all_blank <= 1'b1;
    end else begin
      ld_q <= ld_rd;
      ld_idx <= cnt[4:0];
      if (ld_q && (ld_idx < 5'(NCFG)) && (nv_rdata[7:0] != BLANK_BYTE)) begin
        all_blank <= 1'b0; // R16
      end
    end
  end

  // one config byte per entry
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_cfg
      localparam logic [7:0] DEF = ammc_cfg_default(gi);
      localparam bit IS_CFG = (gi < NCFG);
      always_ff @(posedge clk) begin
        if (!resetn) begin
          cfg[gi] <= DEF; // R17
        end else if (ld_q && (ld_idx == 5'(gi))) begin
          cfg[gi] <= nv_rdata[7:0]; // R16
        end else if (IS_CFG && (first_start || do_defaults)) begin
          cfg[gi] <= DEF; // R17 R18
        end else if (sanitize && (gi == 6)) begin
          cfg[gi] <= mode_clean;
        end else if (cfg_wr && (cfg_idx == 5'(gi))) begin
          cfg[gi] <= bus_wdata; // R24
        end
      end
    end
  endgenerate

  // table access and direct duty registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tbl_addr_h <= '0;
      tbl_addr_l <= '0;
      tbl_data_h <= '0;
      duty_h <= '0;
      duty_l <= '0;
    end else if (bus_wr && run) begin
      if (bus_addr == OFS_TBL_ADDR_H) tbl_addr_h <= bus_wdata;
      if (bus_addr == OFS_TBL_ADDR_L) tbl_addr_l <= bus_wdata;
      if (bus_addr == OFS_TBL_DATA_H) tbl_data_h <= bus_wdata;
      if (bus_addr == OFS_DUTY_H) duty_h <= bus_wdata;
      if (bus_addr == OFS_DUTY_L) duty_l <= bus_wdata;
    end
  end

  // update timer and pending update
  always_ff @(posedge clk) begin
    if (!resetn) begin
      base_cnt <= '0;
      mult_cnt <= '0;
      tick_pend <= 1'b0;
      upd_s1 <= 1'b0;
      samp <= '0;
    end else begin
      base_cnt <= base_end ? 17'h0_0000 : base_cnt + 17'h0_0001;
      if (tick) begin
        mult_cnt <= '0;
      end else if (base_end) begin
        mult_cnt <= mult_cnt + 8'h01;
      end
      tick_pend <= tick || (tick_pend && !upd_go); // R23
      upd_s1 <= upd_go;
      if (upd_go) begin
        samp <= adc_sample; // R23
      end
    end
  end

  // demand computation, evaluated on the cycle after the sample
  wire signed [11:0] cur = 12'(pwm_demand);
  wire signed [11:0] samp_s = $signed({2'b00, samp});
  wire signed [12:0] bip_raw = 13'(samp_s - BIP_MID) <<< 1; // R1
  wire signed [11:0] bip_t = (bip_raw < 13'(PWM_NEG)) ? PWM_NEG :
                             (bip_raw > 13'(PWM_POS)) ? PWM_POS :
                             bip_raw[11:0]; // R1 R2
  wire signed [11:0] slew_s = $signed({4'h0, slew_limit});
  wire signed [11:0] sp_s = $signed({2'b00, setpoint});
  wire signed [11:0] spd_raw = (samp_s < sp_s) ? cur + slew_s :
                               (samp_s > sp_s) ? cur - slew_s : cur; // R3
  wire signed [11:0] spd_t = (spd_raw < 12'sh000) ? 12'h000 :
                             (spd_raw > PWM_POS) ? PWM_POS : spd_raw; // R4
  wire signed [11:0] tbl_t = 12'($signed(nv_rdata)); // R6
  wire signed [11:0] dir_t = 12'($signed({duty_h[2:0], duty_l}));
  wire signed [11:0] lim_t = bipolar_analog_select ? bip_t : samp_s;
  wire signed [11:0] step = lim_t - cur;
  wire signed [11:0] stepped = (step > slew_s) ? cur + slew_s :
                               (step < -slew_s) ? cur - slew_s : lim_t; // R22 R19
  wire signed [11:0] dir_c = (dir_t > PWM_POS) ? PWM_POS :
                             (dir_t < PWM_NEG) ? PWM_NEG : dir_t;
  wire signed [11:0] mode_t = table_mode_select ? tbl_t : // R8
                              speed_regulate_select ? spd_t :
                              (bipolar_analog_select || unipolar_analog_select) ?
                              stepped : dir_c; // R20
  wire stop = ({2'b00, stop_zone_width} > samp); // R21
  wire signed [11:0] next_demand = stop ? 12'h000 : mode_t; // R21 R19

  // output scaling by the period select
  wire [9:0] mag = pwm_demand[10] ? 10'(-pwm_demand) : pwm_demand[9:0];
  wire [18:0] scaled = mag * ({1'b0, pwm_period_select} + 9'h001); // R19
  wire pwm_zero = (pwm_demand == 11'h000);

  // retry condition for the power stage
  wire rty = run && ((mode_and_recovery_ctrl[BIT_ALL_RETRY] && !bridge_on) || // R9
                     (overcurrent_reenergize && overcurrent_flag) || // R10
                     (mode_and_recovery_ctrl[BIT_OT_RETRY] && overheat_flag)); // R10

  // demand and drive outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwm_demand <= '0;
      pwm_duty <= '0;
      low_side_gate_left <= 1'b0;
      low_side_gate_right <= 1'b0;
      energize_cmd <= 1'b0;
      rty_q <= 1'b0;
    end else begin
      if (upd_s1) begin
        pwm_demand <= next_demand[10:0];
      end
      pwm_duty <= scaled[17:8];
      low_side_gate_left <= pwm_zero && zero_pwm_braking; // R11 R12
      low_side_gate_right <= pwm_zero && zero_pwm_braking; // R11 R12
      rty_q <= rty;
      energize_cmd <= rty && !rty_q; // R9 R10
    end
  end

  // read data mux
  wire [7:0] rd_mux = in_cfg ? cfg[cfg_idx] :
                      (bus_addr == OFS_TBL_ADDR_H) ? tbl_addr_h :
                      (bus_addr == OFS_TBL_ADDR_L) ? tbl_addr_l :
                      (bus_addr == OFS_TBL_DATA_H) ? tbl_data_h :
                      (bus_addr == OFS_DUTY_H) ? duty_h :
                      (bus_addr == OFS_DUTY_L) ? duty_l :
                      (bus_addr == OFS_STATUS_H) ? {!run, 4'h0, pwm_demand[10:8]} :
                      (bus_addr == OFS_STATUS_L) ? pwm_demand[7:0] : 8'h00;

  // registered read answer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata <= '0;
    end else begin
      bus_rdata <= bus_rd ? rd_mux : 8'h00;
    end
  end

  assign busy = !run;
endmodule : ammc_core

// ### tb/ammc_nv_model.sv
`timescale 1ns/10ps
module ammc_nv_model (
  input wire logic clk,
  input wire ammc_pkg::ammc_nv_req_s nv_req,
  output logic [9:0] nv_rdata
);
  import ammc_pkg::*;
  logic [9:0] mem [0:1049];
  // a blank part reads all ones everywhere
  initial begin
    for (int i = 0; i < 1050; i++) begin
      mem[i] = 10'h3FF;
    end
    nv_rdata = 10'h155;
  end
  // writes persist; a read answers one cycle later, otherwise the line keeps toggling
  always @(posedge clk) begin
    if (nv_req.we) begin
      mem[nv_req.addr] <= nv_req.wdata;
    end
    nv_rdata <= nv_req.rd ? mem[nv_req.addr] : ~nv_rdata;
  end
endmodule : ammc_nv_model

// ### tb/ammc_core_assertions.sv
`timescale 1ns/10ps
module ammc_core_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bridge_on,
  input wire logic overcurrent_flag,
  input wire logic overheat_flag,
  input wire ammc_pkg::ammc_pwm_t pwm_demand,
  input wire logic [9:0] pwm_duty,
  input wire logic low_side_gate_left,
  input wire logic low_side_gate_right,
  input wire logic energize_cmd,
  input wire logic busy
);
  import ammc_pkg::*;
  // any cause that may start a re-energize pulse
  wire trip = !bridge_on || overcurrent_flag || overheat_flag;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_gates_pair: assert property (low_side_gate_left == low_side_gate_right)
    else $error("low gates differ");
  chk_brake_zero: assert property (low_side_gate_left |-> $past(pwm_demand) == 11'h000)
    else $error("brake with nonzero demand");
  chk_demand_range: assert property (pwm_demand != 11'h400)
    else $error("demand below -1023");
  chk_energize_pulse: assert property (energize_cmd |=> !energize_cmd)
    else $error("energize longer than one cycle");
  chk_energize_cause: assert property (energize_cmd |-> $past(trip) || $past(trip, 2))
    else $error("energize without cause");
  chk_duty_zero: assert property ($past(pwm_demand) == 0 && $past(pwm_demand, 2) == 0
    |-> pwm_duty == 10'h000)
    else $error("duty without demand");
  chk_load_busy: assert property ($rose(resetn) |-> busy [*8])
    else $error("no load after reset");
  chk_demand_held: assert property (busy && $past(busy, 3) |-> $stable(pwm_demand))
    else $error("demand moved while busy");
  // main scenarios
  cover property (energize_cmd);
  cover property (low_side_gate_left);
  cover property (pwm_demand == 11'h401);
endmodule : ammc_core_chk

bind ammc_core ammc_core_chk chk_i (
  .clk(clk),
  .resetn(resetn),
  .bridge_on(bridge_on),
  .overcurrent_flag(overcurrent_flag),
  .overheat_flag(overheat_flag),
  .pwm_demand(pwm_demand),
  .pwm_duty(pwm_duty),
  .low_side_gate_left(low_side_gate_left),
  .low_side_gate_right(low_side_gate_right),
  .energize_cmd(energize_cmd),
  .busy(busy)
);

// ### tb/analog_motor_mode_control_bench.sv
`timescale 1ns/10ps
module analog_motor_mode_control_bench;
  import ammc_pkg::*;
  logic clk = 0, resetn = 0, bus_wr = 0, bus_rd = 0;
  logic bridge_on = 1, overcurrent_flag = 0, overheat_flag = 0;
  logic energize_cmd, busy, low_side_gate_left, low_side_gate_right;
  logic [5:0] bus_addr = 0;
  logic [7:0] bus_wdata = 0, bus_rdata;
  logic [9:0] adc_sample = 10'h200, nv_rdata, pwm_duty;
  ammc_nv_req_s nv_req;
  ammc_pwm_t pwm_demand;
  int fails = 0, comparisons = 0;
  // free-running clock
  always #5 clk = ~clk;
  ammc_core #(.BASE_CYC(20)) dut (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .adc_sample(adc_sample), .bridge_on(bridge_on), .overcurrent_flag(overcurrent_flag),
    .overheat_flag(overheat_flag), .nv_req(nv_req), .nv_rdata(nv_rdata),
    .pwm_demand(pwm_demand), .pwm_duty(pwm_duty), .low_side_gate_left(low_side_gate_left),
    .low_side_gate_right(low_side_gate_right), .energize_cmd(energize_cmd), .busy(busy));
  ammc_nv_model nv (.clk(clk), .nv_req(nv_req), .nv_rdata(nv_rdata));
  task automatic cmp(input logic [10:0] g, input logic [10:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_rd <= 1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 0;
    #1 cmp({3'h0, bus_rdata}, {3'h0, e});
  endtask : rd
  task automatic wait_idle;
    #1;
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    cmp({10'h0, busy}, 11'h000);
  endtask : wait_idle
  task automatic do_reset;
    @(posedge clk);
    resetn <= 0;
    repeat (4) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    wait_idle();
  endtask : do_reset
  // new sample, then enough updates for the demand to settle
  task automatic settle(input logic [9:0] s, input logic [10:0] e);
    @(posedge clk);
    adc_sample <= s;
    repeat (400) @(posedge clk);
    #1 cmp(pwm_demand, e);
  endtask : settle
  // wait for the next move of the demand
  task automatic step(input logic [10:0] e);
    logic [10:0] old;
    old = pwm_demand;
    for (int n = 0; n < 100 && pwm_demand === old; n++) begin
      @(posedge clk);
      #1;
    end
    cmp(pwm_demand, e);
  endtask : step
  task automatic t_defaults;
    logic [7:0] d [10] = '{8'h04, 8'hFF, 8'h01, 8'h04, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00,
      8'h00};
    for (int i = 0; i < 10; i++) begin
      rd(6'h09 + 6'(i), d[i]);
    end
    rd(6'h3F, 8'h00);
  endtask : t_defaults
  task automatic t_bipolar;
    wr(OFS_STOP_ZONE, 8'h00);
    wr(OFS_SLEW, 8'hFF);
    wr(OFS_MODE_CTRL, 8'h02);
    settle(10'h3FF, 11'h3FE);
    cmp({1'b0, pwm_duty}, 11'h3FE);
    settle(10'h000, 11'h401);
    wr(OFS_STOP_ZONE, 8'h08);
    settle(10'h005, 11'h000);
    wr(OFS_STOP_ZONE, 8'h00);
    wr(OFS_MODE_CTRL, 8'h82);
    settle(10'h200, 11'h000);
    cmp({10'h0, low_side_gate_left & low_side_gate_right}, 11'h001);
    wr(OFS_MODE_CTRL, 8'h02);
    repeat (60) @(posedge clk);
    #1 cmp({10'h0, low_side_gate_left | low_side_gate_right}, 11'h000);
  endtask : t_bipolar
  task automatic t_slew;
    wr(OFS_SLEW, 8'h04);
    @(posedge clk);
    adc_sample <= 10'h3FF;
    step(11'h004);
    step(11'h008);
    wr(OFS_SLEW, 8'hFF);
  endtask : t_slew
  task automatic t_speed;
    wr(OFS_REFRESH_MULT, 8'h02);
    wr(OFS_SETPOINT_H, 8'h02);
    wr(OFS_SETPOINT_L, 8'h00);
    rd(OFS_SETPOINT_H, 8'h02);
    wr(OFS_MODE_CTRL, 8'h04);
    settle(10'h064, 11'h3FF);
    settle(10'h384, 11'h000);
  endtask : t_speed
  task automatic t_table;
    wr(OFS_TBL_ADDR_H, 8'h01);
    wr(OFS_TBL_ADDR_L, 8'h23);
    wr(OFS_TBL_DATA_H, 8'h03);
    wr(OFS_TBL_DATA_L, 8'h81);
    wr(OFS_SLEW, 8'h01);
    wr(OFS_MODE_CTRL, 8'h00);
    adc_sample <= 10'h123;
    wr(OFS_MODE_CTRL, 8'h08);
    step(11'h781);
    wr(OFS_CMD, CMD_TBL_RESTORE);
    wait_idle();
    settle(10'h123, 11'h000);
    wr(OFS_SLEW, 8'hFF);
  endtask : t_table
  // direct duty with no mode bit, then unipolar with period scaling
  task automatic t_direct;
    wr(OFS_DUTY_H, 8'h03);
    wr(OFS_DUTY_L, 8'hFF);
    wr(OFS_MODE_CTRL, 8'h00);
    settle(10'h200, 11'h3FF);
    wr(OFS_MODE_CTRL, 8'h01);
    settle(10'h123, 11'h123);
    wr(OFS_PERIOD_SEL, 8'h7F);
    repeat (3) @(posedge clk);
    #1 cmp({1'b0, pwm_duty}, 11'h091);
  endtask : t_direct
  // bit 3 stands for a control run with no retry bit and every cause present
  task automatic t_retry;
    int n;
    for (int b = 3; b < 7; b++) begin
      n = 0;
      wr(OFS_MODE_CTRL, (b > 3) ? 8'(1 << b) : 8'h00);
      bridge_on <= !(b == 3 || b == 4);
      overcurrent_flag <= (b == 3 || b == 5);
      overheat_flag <= (b == 3 || b == 6);
      repeat (10) begin
        @(posedge clk);
        #1 n += int'(energize_cmd === 1'b1);
      end
      bridge_on <= 1;
      overcurrent_flag <= 0;
      overheat_flag <= 0;
      cmp(11'(n), (b == 3) ? 11'h000 : 11'h001);
    end
  endtask : t_retry
  task automatic t_store;
    wr(OFS_USER_FIRST, 8'h5A);
    wr(OFS_SLEW, 8'h11);
    wr(OFS_CMD, CMD_DEFAULTS);
    rd(OFS_SLEW, 8'h04);
    rd(OFS_USER_FIRST, 8'h5A);
    wr(OFS_SLEW, 8'h22);
    wr(OFS_CMD, CMD_STORE);
    wait_idle();
    do_reset();
    rd(OFS_SLEW, 8'h22);
    rd(OFS_USER_FIRST, 8'h5A);
  endtask : t_store
  task automatic report_and_stop;
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    do_reset();
    t_defaults();
    t_bipolar();
    t_slew();
    t_speed();
    t_table();
    t_direct();
    t_retry();
    t_store();
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule : analog_motor_mode_control_bench
